// File: common/vout_setpoint_map.vh
// Command codes, limits and reset constants of the setpoint adjust registers.
// Assumes it is included by bare name from the rtl files; definitions only.
`ifndef VOUT_SETPOINT_MAP_VH
`define VOUT_SETPOINT_MAP_VH

// ============================================================
// Command codes (byte offsets of the paged commands)
`define OFS_OUTPUT_TRIM            8'h22
`define OFS_OUTPUT_CAL_OFFSET      8'h23
`define OFS_OUTPUT_VOLTAGE_CEILING 8'h24

// ============================================================
// Page selection
`define PAGE_ALL                   8'hff

// ============================================================
// Reset values
`define RST_OUTPUT_TRIM            16'h0000
`define RST_OUTPUT_CAL_OFFSET      16'h0000
`define RST_CEILING_BEFORE_STRAP   16'h0000

// ============================================================
// Scaling: every value is counts of 2^-13 V (exponent -13)
`define VOUT_EXPONENT_SHIFT        13
// 150 mV in counts, rounded toward zero: 0.150 * 8192 = 1228.8
`define ADJUST_SPAN_COUNTS         16'h04cc
// 5.5 V in counts: 5.5 * 8192 = 45056
`define CEILING_LIMIT_COUNTS       16'hb000
// Strap to ceiling factor 1.15 as 9420 / 8192 (1.14990)
`define CEIL_STRAP_MULT            14'h24cc

// ============================================================
// Strap capture: edges after reset release before the ceiling loads
`define STRAP_LOAD_DELAY           2'h3

`endif

// File: rtl/setpoint_clamp.v
// One page of setpoint arithmetic: target plus trim plus offset, clamped.
// Assumes all inputs are registered values on the same clock; purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "vout_setpoint_map.vh"

module setpoint_clamp (
    // Commanded target, unsigned counts of 2^-13 V
    input  wire [15:0] target,
    // Signed adjustments, counts of 2^-13 V
    input  wire [15:0] trim,
    input  wire [15:0] cal_offset,
    // Unsigned ceiling, counts of 2^-13 V
    input  wire [15:0] ceiling,
    // Result
    output reg  [15:0] setpoint,
    output reg         clamped
);

    // ============================================================
    // Span limit
    // The adjustments are saturated to the supported span so that a wild
    // calibration write can never swing the rail further than intended.
    function [17:0] sat_span;
        input [15:0] v;
        reg signed [17:0] s;
        begin
            s = {{2{v[15]}}, v};
            if (s > $signed({2'b00, `ADJUST_SPAN_COUNTS})) begin
                sat_span = {2'b00, `ADJUST_SPAN_COUNTS};
            end else if (s < -$signed({2'b00, `ADJUST_SPAN_COUNTS})) begin
                sat_span = 18'h0 - {2'b00, `ADJUST_SPAN_COUNTS};
            end else begin
                sat_span = s;
            end
        end
    endfunction

    wire signed [17:0] trim_ext   = sat_span(trim);
    wire signed [17:0] offset_ext = sat_span(cal_offset);
    wire signed [17:0] target_ext = {2'b00, target};
    wire signed [17:0] sum        = target_ext + trim_ext + offset_ext;

    // ============================================================
    // Clamp: floor at zero, ceiling on top of everything else.
    always @* begin
        if (sum < 18'sd0) begin
            setpoint = 16'h0000;
            clamped  = 1'b0;
        end else if (sum > $signed({2'b00, ceiling})) begin
            setpoint = ceiling;
            clamped  = 1'b1;
        end else begin
            setpoint = sum[15:0];
            clamped  = 1'b0;
        end
    end

endmodule // setpoint_clamp
`default_nettype wire

// File: rtl/vout_setpoint_adjust_regs.v
// Paged output trim, calibration offset and voltage ceiling commands.
// Assumes a command layer on the same clock presents decoded paged accesses,
// and that the strap pins are asynchronous and steady after power-up.
`timescale 1ns/10ps
`default_nettype none
`include "vout_setpoint_map.vh"

module vout_setpoint_adjust_regs #(
    parameter NUM_PAGES = 2
) (
    // Clock and synchronous reset
    input  wire                    clk,
    input  wire                    reset_n,
    // Decoded command port
    input  wire                    cmd_valid,
    input  wire                    cmd_write,
    input  wire [7:0]              cmd_code,
    input  wire [7:0]              cmd_page,
    input  wire [15:0]             cmd_wdata,
    output reg                     rsp_valid,
    output reg                     rsp_error,
    output reg  [15:0]             rsp_rdata,
    // Strap pins and per-page targets
    input  wire [15:0]             setpoint_pin_strap,
    input  wire [NUM_PAGES*16-1:0] target_voltage,
    // Regulation references
    output reg  [NUM_PAGES*16-1:0] setpoint_ref,
    output reg  [NUM_PAGES-1:0]    ceiling_clamp_active,
    output reg                     strap_loaded
);

    // ============================================================
    // Decoding helpers
    // A page hits its own number or the broadcast page.
    function page_hit;
        input [7:0] page;
        input integer idx;
        begin
            page_hit = (page == `PAGE_ALL) || (page == idx[7:0]);
        end
    endfunction

    // Ceiling writes saturate at the largest supported level.
    function [15:0] sat_ceiling;
        input [16:0] v;
        begin
            if (v > {1'b0, `CEILING_LIMIT_COUNTS}) begin
                sat_ceiling = `CEILING_LIMIT_COUNTS;
            end else begin
                sat_ceiling = v[15:0];
            end
        end
    endfunction

    function code_known;
        input [7:0] code;
        begin
            code_known = (code == `OFS_OUTPUT_TRIM) || (code == `OFS_OUTPUT_CAL_OFFSET) ||
                         (code == `OFS_OUTPUT_VOLTAGE_CEILING);
        end
    endfunction

    // ============================================================
    // Strap synchroniser
    // The strap is a pin, so it passes two flops before the multiplier sees it.
    reg  [15:0] strap_meta_reg;
    reg  [15:0] strap_sync_reg;
    reg  [1:0]  strap_wait_reg;
    reg         strap_load_reg;
    wire [29:0] strap_prod = strap_sync_reg * `CEIL_STRAP_MULT;
    wire [15:0] strap_ceiling = sat_ceiling(strap_prod[29:`VOUT_EXPONENT_SHIFT]);

    always @(posedge clk) begin
        if (!reset_n) begin
            strap_meta_reg <= 16'h0000;
            strap_sync_reg <= 16'h0000;
        end else begin
            strap_meta_reg <= setpoint_pin_strap;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // Load the ceiling once, after the synchroniser holds the real strap.
    // Until then the ceiling is zero, which holds the rail safely low.
    always @(posedge clk) begin
        if (!reset_n) begin
            strap_wait_reg <= 2'h0;
            strap_load_reg <= 1'b0;
            strap_loaded   <= 1'b0;
        end else begin
            strap_load_reg <= 1'b0;
            if (!strap_loaded) begin
                if (strap_wait_reg == `STRAP_LOAD_DELAY) begin
                    strap_load_reg <= 1'b1;
                    strap_loaded   <= 1'b1;
                end else begin
                    strap_wait_reg <= strap_wait_reg + 2'h1;
                end
            end
        end
    end

    // ============================================================
    // Per-page registers and arithmetic
    wire        wr = cmd_valid && cmd_write && (strap_loaded || strap_load_reg);
    wire [NUM_PAGES*16-1:0] trim_all;
    wire [NUM_PAGES*16-1:0] offset_all;
    wire [NUM_PAGES*16-1:0] ceiling_all;
    wire [NUM_PAGES*16-1:0] sum_all;
    wire [NUM_PAGES-1:0]    clamp_all;

    genvar g;
    generate
        for (g = 0; g < NUM_PAGES; g = g + 1) begin : page
            reg [15:0] trim_reg;
            reg [15:0] offset_reg;
            reg [15:0] ceiling_reg;
            wire       hit = wr && page_hit(cmd_page, g);

            // Host writes land in the addressed page, or in all pages.
            always @(posedge clk) begin
                if (!reset_n) begin
                    trim_reg    <= `RST_OUTPUT_TRIM;
                    offset_reg  <= `RST_OUTPUT_CAL_OFFSET;
                    ceiling_reg <= `RST_CEILING_BEFORE_STRAP;
                end else begin
                    if (hit && cmd_code == `OFS_OUTPUT_TRIM) begin
                        trim_reg <= cmd_wdata;
                    end
                    if (hit && cmd_code == `OFS_OUTPUT_CAL_OFFSET) begin
                        offset_reg <= cmd_wdata;
                    end
                    // The ceiling follows only its own writes and the strap,
                    // never the target. A host write that lands in the load
                    // cycle has already been acknowledged, so it must win.
                    if (hit && cmd_code == `OFS_OUTPUT_VOLTAGE_CEILING) begin
                        ceiling_reg <= sat_ceiling({1'b0, cmd_wdata});
                    end else if (strap_load_reg) begin
                        ceiling_reg <= strap_ceiling;
                    end
                end
            end

            assign trim_all[g*16 +: 16]    = trim_reg;
            assign offset_all[g*16 +: 16]  = offset_reg;
            assign ceiling_all[g*16 +: 16] = ceiling_reg;

            setpoint_clamp u_clamp (
                .target     (target_voltage[g*16 +: 16]),
                .trim       (trim_reg),
                .cal_offset (offset_reg),
                .ceiling    (ceiling_reg),
                .setpoint   (sum_all[g*16 +: 16]),
                .clamped    (clamp_all[g])
            );
        end
    endgenerate

    // ============================================================
    // Reference outputs, registered so the loop sees glitch-free values.
    always @(posedge clk) begin
        if (!reset_n) begin
            setpoint_ref         <= {NUM_PAGES*16{1'b0}};
            ceiling_clamp_active <= {NUM_PAGES{1'b0}};
        end else begin
            setpoint_ref         <= sum_all;
            ceiling_clamp_active <= clamp_all;
        end
    end

    // ============================================================
    // Read and answer path
    // Reads must name one real page; broadcast reads have no single answer.
    reg        page_ok;
    reg [15:0] rd_word;
    integer    i;

    always @* begin
        page_ok = 1'b0;
        rd_word = 16'h0000;
        for (i = 0; i < NUM_PAGES; i = i + 1) begin
            if (cmd_page == i[7:0]) begin
                page_ok = 1'b1;
                case (cmd_code)
                    `OFS_OUTPUT_TRIM:            rd_word = trim_all[i*16 +: 16];
                    `OFS_OUTPUT_CAL_OFFSET:      rd_word = offset_all[i*16 +: 16];
                    `OFS_OUTPUT_VOLTAGE_CEILING: rd_word = ceiling_all[i*16 +: 16];
                    default:                     rd_word = 16'h0000;
                endcase
            end
        end
    end

    // Every command is answered one cycle later; bad code or page errors.
    always @(posedge clk) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= cmd_valid;
            rsp_error <= 1'b0;
            rsp_rdata <= 16'h0000;
            if (cmd_valid) begin
                if (!code_known(cmd_code)) begin
                    rsp_error <= 1'b1;
                end else if (cmd_write) begin
                    rsp_error <= !(page_ok || cmd_page == `PAGE_ALL) || !(strap_loaded || strap_load_reg);
                end else if (!page_ok) begin
                    rsp_error <= 1'b1;
                end else begin
                    rsp_rdata <= rd_word;
                end
            end
        end
    end

endmodule // vout_setpoint_adjust_regs
`default_nettype wire

// File: test/host_cmd_model.sv
// Host side model: issues decoded paged commands to the device.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model (
    // Clock
    input  wire logic        clk,
    // Command lines toward the device
    output var logic        cmd_valid,
    output var logic        cmd_write,
    output var logic [7:0]  cmd_code,
    output var logic [7:0]  cmd_page,
    output var logic [15:0] cmd_wdata
);
    // ============================================================
    // Drivers
    // Lines start idle so nothing is taken before the first command.
    initial begin
        {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = '0;
    end
    // Whole 16-bit words only; held for the one taking edge.
    task automatic issue(input logic w, input logic [7:0] c, p, input logic [15:0] d);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_page <= p;
        cmd_wdata <= d;
        @(posedge clk);
    endtask
    // Released code and data lines flip so a stale word is never mistaken for a live one.
    task automatic idle;
        cmd_valid <= 1'b0;
        cmd_code <= ~cmd_code;
        cmd_wdata <= ~cmd_wdata;
        @(posedge clk);
    endtask
endmodule // host_cmd_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the setpoint adjust registers.
// Assumes the checker binds itself onto the design.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk, reset_n, cmd_valid, cmd_write, rsp_valid, rsp_error, strap_loaded, ready;
    logic [7:0]  cmd_code, cmd_page;
    logic [15:0] cmd_wdata, rsp_rdata, strap;
    logic [31:0] target, setpoint_ref;
    logic [1:0]  clamp_act;
    logic [16:0] rq[$];
    logic [15:0] m[3][2];
    int          bad_count, n_tests, cycles, k, c;

    // ============================================================
    // Clock, design and host
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    vout_setpoint_adjust_regs #(.NUM_PAGES(2)) vout_setpoint_adjust_regs_inst (.clk(clk), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
        .setpoint_pin_strap(strap), .target_voltage(target), .setpoint_ref(setpoint_ref),
        .ceiling_clamp_active(clamp_act), .strap_loaded(strap_loaded));
    host_cmd_model host_cmd_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata));

    // ============================================================
    // Helpers
    task automatic chk(input string what, input logic [16:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    // Adjustments saturate at the documented span before summing.
    function automatic int sat(input logic [15:0] v);
        return $signed(v) > 1228 ? 1228 : ($signed(v) < -1228 ? -1228 : int'($signed(v)));
    endfunction
    task automatic sp_check;
        int s;
        for (int g = 0; g < 2; g++) begin
            s = target[g*16+:16] + sat(m[0][g]) + sat(m[1][g]);
            s = s < 0 ? 0 : s;
            chk("setpoint", s > m[2][g] ? {1'b1, m[2][g]} : {1'b0, 16'(s)}, {clamp_act[g], setpoint_ref[g*16+:16]});
        end
    endtask
    // Note the expected answer, then issue the command.
    task automatic op(input logic w, input logic [7:0] c, p, input logic [15:0] d);
        logic e;
        logic [15:0] r;
        e = c < 8'h22 || c > 8'h24 || (p > 1 && !(w && p == 8'hff)) || (w && !ready);
        r = 16'h0000;
        for (int g = 0; g < 2; g++)
            if (!e && (p == g || p == 8'hff)) begin
                if (w)
                    m[c-8'h22][g] = (c == 8'h24 && d > 16'hb000) ? 16'hb000 : d;
                else
                    r = m[c-8'h22][g];
            end
        rq.push_back({e, r});
        host_cmd_model_inst.issue(w, c, p, d);
    endtask
    task tally_and_finish;
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ============================================================
    // Checking and time limit
    // Each response pulse is matched against the oldest note.
    always @(posedge clk) begin
        if (rsp_valid === 1'b1)
            chk("response", rq.pop_front(), {rsp_error, rsp_rdata});
    end
    // A hang counts as a failure.
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ============================================================
    // Scenarios
    initial begin
        void'($urandom(76751));
        {reset_n, ready, target} = '0;
        m = '{default: 16'h0000};
        strap = 16'h2000;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        op(1, 8'h22, 0, 16'h1234);
        op(0, 8'h24, 1, 0);
        host_cmd_model_inst.idle();
        for (k = 0; k < 20 && strap_loaded !== 1'b1; k++)
            @(posedge clk);
        chk("strap_loaded", 17'h00001, {16'h0000, strap_loaded});
        ready = 1'b1;
        m[2][0] = 16'((32'(strap) * 9420) >> 13);
        m[2][1] = m[2][0];
        for (c = 8'h22; c < 8'h25; c++)
            for (k = 0; k < 2; k++)
                op(0, c, k, 0);
        for (c = 8'h22; c < 8'h25; c++)
            for (k = 0; k < 4; k++)
                op(k / 2, c, k % 2, 16'($urandom));
        op(1, 8'h24, 0, 16'hffff);
        op(0, 8'h24, 0, 0);
        op(1, 8'h21, 0, 16'h0001);
        op(0, 8'h22, 2, 0);
        op(0, 8'h23, 8'hff, 0);
        op(1, 8'h23, 8'hff, 16'hfff0);
        op(0, 8'h23, 1, 0);
        for (k = 0; k < 12; k++) begin
            op(1, 8'h22, k % 2, 16'($urandom_range(0, 3072)) - 16'h0600);
            op(1, 8'h23, k % 2, 16'($urandom_range(0, 3072)) - 16'h0600);
            op(1, 8'h24, k % 2, 16'h1000 + 16'($urandom_range(0, 16'h9000)));
            target <= {2{k > 8 ? 16'($urandom_range(0, 2048)) : 16'($urandom)}};
            host_cmd_model_inst.idle();
            repeat (2) @(posedge clk);
            sp_check();
            target <= ~target;
            op(0, 8'h24, k % 2, 0);
            host_cmd_model_inst.idle();
            @(posedge clk);
            sp_check();
        end
        repeat (3) @(posedge clk);
        // Every note must have met its answer; a missing response leaves one behind.
        chk("pending notes", 17'h00000, 17'(rq.size()));
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire

// File: test/vout_setpoint_checker.sv
// Assertions on the setpoint adjust register port and references.
// Assumes it is bound onto the top design module, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module vout_setpoint_checker #(parameter NUM_PAGES = 2) (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   reset_n,
    // Command and response
    input wire logic                   cmd_valid,
    input wire logic                   cmd_write,
    input wire logic [7:0]             cmd_code,
    input wire logic [7:0]             cmd_page,
    input wire logic                   rsp_valid,
    input wire logic                   rsp_error,
    input wire logic [15:0]            rsp_rdata,
    // References
    input wire logic [NUM_PAGES*16-1:0] setpoint_ref,
    input wire logic [NUM_PAGES-1:0]    ceiling_clamp_active,
    input wire logic                   strap_loaded
);
    // ============================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid)
        else $error("response missing after command");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("response without command");
    a_bad_code_err: assert property (cmd_valid && (cmd_code < 8'h22 || cmd_code > 8'h24) |=> rsp_error)
        else $error("unknown code accepted");
    a_bad_page_err: assert property (cmd_valid && cmd_page >= NUM_PAGES && !(cmd_write && cmd_page == 8'hff)
        |=> rsp_error)
        else $error("bad page accepted");
    a_quiet_rdata: assert property (rsp_valid && (rsp_error || $past(cmd_write)) |-> rsp_rdata == 16'h0000)
        else $error("read data on write or error");
    a_early_write_err: assert property (cmd_valid && cmd_write && !strap_loaded ##1 !strap_loaded
        |-> rsp_error)
        else $error("write accepted before ceiling load");
    a_strap_load_time: assert property ($rose(reset_n) |-> !strap_loaded ##[3:5] strap_loaded)
        else $error("ceiling not loaded in time");
    a_strap_sticky: assert property (strap_loaded |=> strap_loaded)
        else $error("ceiling load flag dropped");
    a_zero_ceiling_out: assert property (!strap_loaded |-> setpoint_ref == '0)
        else $error("output above empty ceiling");
    // Main scenarios seen.
    c_write_ok: cover property (cmd_valid && cmd_write ##1 rsp_valid && !rsp_error);
    c_refused: cover property (rsp_valid && rsp_error);
    c_clamped: cover property (ceiling_clamp_active[0]);
endmodule // vout_setpoint_checker
bind vout_setpoint_adjust_regs vout_setpoint_checker #(.NUM_PAGES(NUM_PAGES)) checker_inst (.clk(clk),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .setpoint_ref(setpoint_ref),
    .ceiling_clamp_active(ceiling_clamp_active), .strap_loaded(strap_loaded));
`default_nettype wire
